// ===== core/iaem_pkg.sv
package iaem_pkg;

    // register bus geometry
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PROTOCOL = 8'h04;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
    localparam logic [7:0] OFS_SRC_MASK = 8'h0C;
    localparam logic [7:0] OFS_DST_ADDR = 8'h10;
    localparam logic [7:0] OFS_DST_MASK = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // control register field positions
    localparam int CTL_ENABLE = 0;
    localparam int CTL_DENY = 1;
    localparam int CTL_PROTO_LSB = 2;
    localparam int CTL_TTL_LSB = 5;
    localparam int CTL_FRAG_LSB = 7;
    localparam int CTL_OPT_LSB = 9;
    localparam int CTL_SRC_LSB = 11;
    localparam int CTL_DST_LSB = 13;
    localparam int CTL_USED_W = 15;

    // status register field positions
    localparam int STS_LAST_MATCH = 0;
    localparam int STS_LAST_DROP = 1;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_PROTOCOL = 8'h00;

    // well-known IPv4 protocol numbers
    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;

    // header length in 32-bit words without options
    localparam logic [3:0] HDR_WORDS_PLAIN = 4'h5;

    typedef enum logic [2:0] {
        PROTO_ANY = 3'h0,
        PROTO_SPECIFIC = 3'h1,
        PROTO_SEL_ICMP = 3'h2,
        PROTO_SEL_UDP = 3'h3,
        PROTO_SEL_TCP = 3'h4
    } iaem_proto_mode_t;

    // shared by time-to-live (no = zero, yes = non-zero), fragment, options
    typedef enum logic [1:0] {
        TRI_ANY = 2'h0,
        TRI_NO = 2'h1,
        TRI_YES = 2'h2
    } iaem_tri_mode_t;

    typedef enum logic [1:0] {
        ADDR_ANY = 2'h0,
        ADDR_HOST = 2'h1,
        ADDR_NETWORK = 2'h2
    } iaem_addr_mode_t;

    typedef struct packed {
        logic is_ipv4;
        logic [7:0] protocol;
        logic [7:0] time_to_live;
        logic more_fragments_bit;
        logic [12:0] fragment_position_field;
        logic [3:0] header_words;
        logic [31:0] source_ipv4_address;
        logic [31:0] destination_ipv4_address;
    } iaem_frame_t;

endpackage : iaem_pkg

// ===== core/iaem_matcher.sv
// Contract
// - protocol any ignores protocol number
// - specific mode matches configured 8-bit protocol
// - icmp choice matches only icmp frames
// - udp choice matches only udp frames
// - tcp choice matches only tcp frames
// - ttl zero refuses frames with ttl above zero
// - ttl non-zero needs ttl above zero; any ignores
// - fragment test: more-fragments or nonzero offset
// - options test: no, yes, or ignore
// - source any skips source address compare
// - source host compares full source address
// - source network compares only masked bits
// - source address for host/network, mask network only
// - destination any skips destination compare
// - destination host needs exact address equality
// - destination network compares only masked bits
// - destination address for host/network, mask network
// - only ipv4 frames can match this entry
// - matching frame on deny entry is dropped
// - counter increments once per matching frame
module iaem_matcher #(
    parameter int COUNT_W = 32
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [iaem_pkg::REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [iaem_pkg::REG_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [iaem_pkg::REG_DATA_W-1:0] REG_RDATA,
    input wire logic FRAME_VALID,
    input wire iaem_pkg::iaem_frame_t FRAME,
    output logic MATCH,
    output logic DROP
);
    import iaem_pkg::*;

    // software-held configuration
    logic enable;
    logic deny;
    iaem_proto_mode_t proto_mode;
    iaem_tri_mode_t ttl_mode;
    iaem_tri_mode_t frag_mode;
    iaem_tri_mode_t opt_mode;
    iaem_addr_mode_t src_mode;
    iaem_addr_mode_t dst_mode;
    logic [7:0] proto_value;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;

    // block state
    logic [COUNT_W-1:0] match_count;
    logic last_match;
    logic last_drop;

    // decision terms
    logic proto_ok;
    logic ttl_ok;
    logic frag_ok;
    logic opt_ok;
    logic src_ok;
    logic dst_ok;
    logic hit;
    logic [REG_DATA_W-1:0] next_rdata;
    logic [REG_DATA_W-1:0] control_word;

    // a reserved tri encoding never satisfies, so a bad setting fails safe
    function automatic logic tri_ok(
        input iaem_tri_mode_t mode,
        input logic flag
    );
        case (mode)
            TRI_ANY: tri_ok = 1'b1;
            TRI_NO: tri_ok = !flag;
            TRI_YES: tri_ok = flag;
            default: tri_ok = 1'b0;
        endcase
    endfunction : tri_ok

    function automatic logic addr_ok(
        input iaem_addr_mode_t mode,
        input logic [31:0] seen,
        input logic [31:0] want,
        input logic [31:0] mask
    );
        case (mode)
            ADDR_ANY: addr_ok = 1'b1;
            ADDR_HOST: addr_ok = (seen == want);
            ADDR_NETWORK: addr_ok = ((seen & mask) == (want & mask));
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    always_comb
    begin
        case (proto_mode)
            PROTO_ANY: proto_ok = 1'b1;
            PROTO_SPECIFIC: proto_ok = (FRAME.protocol == proto_value);
            PROTO_SEL_ICMP: proto_ok = (FRAME.protocol == PROTO_ICMP);
            PROTO_SEL_UDP: proto_ok = (FRAME.protocol == PROTO_UDP);
            PROTO_SEL_TCP: proto_ok = (FRAME.protocol == PROTO_TCP);
            default: proto_ok = 1'b0;
        endcase
    end

    // no means ttl must be zero, yes means ttl must be above zero
    assign ttl_ok = tri_ok(ttl_mode, FRAME.time_to_live != 8'h00);

    assign frag_ok = tri_ok(frag_mode, FRAME.more_fragments_bit
        || (FRAME.fragment_position_field != 13'h0000));

    assign opt_ok = tri_ok(opt_mode,
        FRAME.header_words > HDR_WORDS_PLAIN);

    // the mask only enters in network mode, the address in host or network
    assign src_ok = addr_ok(src_mode, FRAME.source_ipv4_address,
        src_addr, src_mask);
    assign dst_ok = addr_ok(dst_mode, FRAME.destination_ipv4_address,
        dst_addr, dst_mask);

    assign hit = FRAME_VALID && enable && FRAME.is_ipv4
        && proto_ok && ttl_ok && frag_ok && opt_ok
        && src_ok && dst_ok;

    // configuration writes
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            enable <= 1'b0;
            deny <= 1'b0;
            proto_mode <= PROTO_ANY;
            ttl_mode <= TRI_ANY;
            frag_mode <= TRI_ANY;
            opt_mode <= TRI_ANY;
            src_mode <= ADDR_ANY;
            dst_mode <= ADDR_ANY;
        end
        else if (REG_WR && REG_ADDR == OFS_CONTROL)
        begin
            enable <= REG_WDATA[CTL_ENABLE];
            deny <= REG_WDATA[CTL_DENY];
            proto_mode <= iaem_proto_mode_t'(REG_WDATA[CTL_PROTO_LSB +: 3]);
            ttl_mode <= iaem_tri_mode_t'(REG_WDATA[CTL_TTL_LSB +: 2]);
            frag_mode <= iaem_tri_mode_t'(REG_WDATA[CTL_FRAG_LSB +: 2]);
            opt_mode <= iaem_tri_mode_t'(REG_WDATA[CTL_OPT_LSB +: 2]);
            src_mode <= iaem_addr_mode_t'(REG_WDATA[CTL_SRC_LSB +: 2]);
            dst_mode <= iaem_addr_mode_t'(REG_WDATA[CTL_DST_LSB +: 2]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            proto_value <= RST_PROTOCOL;
            src_addr <= RST_WORD;
            src_mask <= RST_WORD;
            dst_addr <= RST_WORD;
            dst_mask <= RST_WORD;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == OFS_PROTOCOL)
            begin
                proto_value <= REG_WDATA[7:0];
            end
            else if (REG_ADDR == OFS_SRC_ADDR)
            begin
                src_addr <= REG_WDATA;
            end
            else if (REG_ADDR == OFS_SRC_MASK)
            begin
                src_mask <= REG_WDATA;
            end
            else if (REG_ADDR == OFS_DST_ADDR)
            begin
                dst_addr <= REG_WDATA;
            end
            else if (REG_ADDR == OFS_DST_MASK)
            begin
                dst_mask <= REG_WDATA;
            end
        end
    end

    // a hit in the same cycle as a clearing write is counted, not lost
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            match_count <= '0;
        end
        else if (REG_WR && REG_ADDR == OFS_COUNT)
        begin
            match_count <= hit ? COUNT_W'(1) : '0;
        end
        else if (hit)
        begin
            match_count <= match_count + COUNT_W'(1);
        end
    end

    // decision outputs, one cycle after the frame is presented
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            MATCH <= 1'b0;
            DROP <= 1'b0;
        end
        else
        begin
            MATCH <= hit;
            DROP <= hit && deny;
        end
    end

    // outcome of the most recent frame, held until the next one
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            last_match <= 1'b0;
            last_drop <= 1'b0;
        end
        else if (FRAME_VALID)
        begin
            last_match <= hit;
            last_drop <= hit && deny;
        end
    end

    always_comb
    begin
        control_word = '0;
        control_word[CTL_ENABLE] = enable;
        control_word[CTL_DENY] = deny;
        control_word[CTL_PROTO_LSB +: 3] = proto_mode;
        control_word[CTL_TTL_LSB +: 2] = ttl_mode;
        control_word[CTL_FRAG_LSB +: 2] = frag_mode;
        control_word[CTL_OPT_LSB +: 2] = opt_mode;
        control_word[CTL_SRC_LSB +: 2] = src_mode;
        control_word[CTL_DST_LSB +: 2] = dst_mode;
    end

    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = '0;
        if (REG_ADDR == OFS_CONTROL)
        begin
            next_rdata = control_word;
        end
        else if (REG_ADDR == OFS_PROTOCOL)
        begin
            next_rdata[7:0] = proto_value;
        end
        else if (REG_ADDR == OFS_SRC_ADDR)
        begin
            next_rdata = src_addr;
        end
        else if (REG_ADDR == OFS_SRC_MASK)
        begin
            next_rdata = src_mask;
        end
        else if (REG_ADDR == OFS_DST_ADDR)
        begin
            next_rdata = dst_addr;
        end
        else if (REG_ADDR == OFS_DST_MASK)
        begin
            next_rdata = dst_mask;
        end
        else if (REG_ADDR == OFS_COUNT)
        begin
            next_rdata = REG_DATA_W'(match_count);
        end
        else if (REG_ADDR == OFS_STATUS)
        begin
            next_rdata[STS_LAST_MATCH] = last_match;
            next_rdata[STS_LAST_DROP] = last_drop;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG_RDATA <= '0;
        end
        else if (REG_RD)
        begin
            REG_RDATA <= next_rdata;
        end
        else
        begin
            REG_RDATA <= '0;
        end
    end

endmodule : iaem_matcher

// ===== sim/iaem_matcher_checker.sv
module iaem_matcher_checker #(
    parameter int COUNT_W = 32
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic FRAME_VALID,
    input wire iaem_pkg::iaem_frame_t FRAME,
    input wire logic MATCH,
    input wire logic DROP
);
    import iaem_pkg::*;
    // shadow of the control word, seen by frames one cycle after the write
    logic [14:0] ctl;
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ctl <= 15'h0000;
        else if (REG_WR && REG_ADDR == OFS_CONTROL)
            ctl <= REG_WDATA[14:0];
    end
    // shadow of the specific protocol value
    logic [7:0] proto;
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            proto <= RST_PROTOCOL;
        else if (REG_WR && REG_ADDR == OFS_PROTOCOL)
            proto <= REG_WDATA[7:0];
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    a_drop_needs_deny: assert property (
        DROP |-> MATCH && $past(ctl[1]))
        else $error("drop without a deny match");
    a_match_needs_frame: assert property (MATCH |-> $past(FRAME_VALID))
        else $error("match without a frame");
    a_ipv4_only: assert property (
        FRAME_VALID && !FRAME.is_ipv4 |=> !MATCH)
        else $error("non ipv4 frame matched");
    a_ttl_zero_only: assert property (FRAME_VALID && ctl[6:5] == TRI_NO
        && FRAME.time_to_live != 8'h00 |=> !MATCH)
        else $error("live frame matched zero ttl entry");
    a_frag_excluded: assert property (FRAME_VALID && ctl[8:7] == TRI_NO
        && (FRAME.more_fragments_bit
        || FRAME.fragment_position_field != 13'h0000) |=> !MATCH)
        else $error("fragment matched no-fragment entry");
    a_opt_excluded: assert property (FRAME_VALID && ctl[10:9] == TRI_NO
        && FRAME.header_words > HDR_WORDS_PLAIN |=> !MATCH)
        else $error("options frame matched no-options entry");
    a_icmp_only: assert property (
        FRAME_VALID && ctl[4:2] == PROTO_SEL_ICMP
        && FRAME.protocol != PROTO_ICMP |=> !MATCH)
        else $error("non icmp frame matched icmp entry");
    a_tcp_only: assert property (
        FRAME_VALID && ctl[4:2] == PROTO_SEL_TCP
        && FRAME.protocol != PROTO_TCP |=> !MATCH)
        else $error("non tcp frame matched tcp entry");
    a_udp_only: assert property (
        FRAME_VALID && ctl[4:2] == PROTO_SEL_UDP
        && FRAME.protocol != PROTO_UDP |=> !MATCH)
        else $error("non udp frame matched udp entry");
    a_specific_only: assert property (
        FRAME_VALID && ctl[4:2] == PROTO_SPECIFIC
        && FRAME.protocol != proto |=> !MATCH)
        else $error("other protocol matched specific entry");
    c_match_seen: cover property (MATCH);
    c_drop_seen: cover property (DROP);
    c_count_read: cover property (REG_RD && REG_ADDR == OFS_COUNT);
endmodule : iaem_matcher_checker

bind iaem_matcher iaem_matcher_checker #(.COUNT_W(COUNT_W))
    iaem_matcher_checker_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FRAME_VALID(FRAME_VALID),
    .FRAME(FRAME), .MATCH(MATCH), .DROP(DROP));

// ===== sim/iaem_ingress.sv
module iaem_ingress (
    input wire logic CORE_CLK,
    output logic FRAME_VALID,
    output iaem_pkg::iaem_frame_t FRAME
);
    timeunit 1ns;
    timeprecision 100ps;
    import iaem_pkg::*;
    initial
    begin
        FRAME_VALID = 1'b0;
        FRAME = '0;
    end
    // idle header bus carries the inverse so a stale header cannot pass
    task automatic send(input iaem_frame_t f);
        @(posedge CORE_CLK);
        FRAME_VALID <= 1'b1;
        FRAME <= f;
        @(posedge CORE_CLK);
        FRAME_VALID <= 1'b0;
        FRAME <= ~f;
    endtask : send
endmodule : iaem_ingress

// ===== sim/iaem_matcher_bench.sv
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module iaem_matcher_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import iaem_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic frame_valid;
    iaem_frame_t frame;
    logic match;
    logic drop;
    logic deny_on = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    iaem_frame_t base = '{1'b1, PROTO_TCP, 8'h40, 1'b0, 13'h0000,
        HDR_WORDS_PLAIN, 32'h0A00_0001, 32'hC0A8_0105};
    always #2.5 core_clk = ~core_clk;
    iaem_ingress iaem_ingress_inst (.CORE_CLK(core_clk),
        .FRAME_VALID(frame_valid), .FRAME(frame));
    iaem_matcher iaem_matcher_inst (.CORE_CLK(core_clk), .ARST_N(arst_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FRAME_VALID(frame_valid),
        .FRAME(frame), .MATCH(match), .DROP(drop));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic fr(input iaem_frame_t f, input logic e);
        iaem_ingress_inst.send(f);
        #1;
        `CHK(match, e)
        `CHK(drop, e & deny_on)
    endtask : fr
    task automatic t_regs;
        rd(OFS_CONTROL, 32'h0000_0000);
        rd(OFS_COUNT, 32'h0000_0000);
        wr(OFS_PROTOCOL, 32'h0000_01FF);
        rd(OFS_PROTOCOL, 32'h0000_00FF);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd(OFS_STATUS, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
    endtask : t_regs
    task automatic t_proto;
        logic [7:0] sel [5] = '{8'h00, 8'hFF, PROTO_ICMP, PROTO_UDP,
            PROTO_TCP};
        iaem_frame_t f = base;
        for (int m = 0; m < 5; m++)
        begin
            wr(OFS_CONTROL, 32'(1 + (m << CTL_PROTO_LSB)));
            for (int p = 1; p < 5; p++)
            begin
                f.protocol = sel[p];
                fr(f, m == 0 || m == p);
            end
        end
    endtask : t_proto
    task automatic t_tri;
        iaem_frame_t y [4] = '{base, base, base, base};
        iaem_frame_t n [4] = '{base, base, base, base};
        int lsb [4] = '{CTL_TTL_LSB, CTL_FRAG_LSB, CTL_FRAG_LSB, CTL_OPT_LSB};
        n[0].time_to_live = 8'h00;
        y[1].more_fragments_bit = 1'b1;
        y[2].fragment_position_field = 13'h0001;
        y[3].header_words = 4'h6;
        for (int k = 0; k < 4; k++)
            for (int m = 0; m < 3; m++)
            begin
                wr(OFS_CONTROL, 32'(1 + (m << lsb[k])));
                fr(y[k], m != 1);
                fr(n[k], m != 2);
            end
    endtask : t_tri
    task automatic t_addr;
        iaem_frame_t f = base;
        iaem_frame_t g = base;
        f.source_ipv4_address = 32'h0A00_00FF;
        f.destination_ipv4_address = 32'hC0A8_0106;
        g.source_ipv4_address = 32'h0B00_0001;
        g.destination_ipv4_address = 32'hC0A9_0105;
        wr(OFS_SRC_ADDR, 32'h0A00_00FF);
        wr(OFS_SRC_MASK, 32'hFFFF_FF00);
        wr(OFS_DST_ADDR, 32'hC0A8_0105);
        wr(OFS_DST_MASK, 32'hFFFF_0000);
        rd(OFS_SRC_ADDR, 32'h0A00_00FF);
        rd(OFS_DST_MASK, 32'hFFFF_0000);
        for (int s = 0; s < 2; s++)
            for (int m = 0; m < 3; m++)
            begin
                wr(OFS_CONTROL,
                    32'(1 + (m << (s ? CTL_DST_LSB : CTL_SRC_LSB))));
                fr(base, s == 1 || m != 1);
                fr(f, s == 0 || m != 1);
                fr(g, m == 0);
            end
    endtask : t_addr
    task automatic t_deny;
        iaem_frame_t f = base;
        f.is_ipv4 = 1'b0;
        wr(OFS_COUNT, 32'h0000_0000);
        wr(OFS_CONTROL, 32'h0000_0003);
        deny_on = 1'b1;
        fr(base, 1'b1);
        fr(f, 1'b0);
        fr(base, 1'b1);
        rd(OFS_COUNT, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0003);
        wr(OFS_CONTROL, 32'h0000_0033);
        rd(OFS_CONTROL, 32'h0000_0033);
        fr(base, 1'b0);
        deny_on = 1'b0;
        rd(OFS_COUNT, 32'h0000_0002);
        wr(OFS_COUNT, 32'h0000_0000);
        rd(OFS_COUNT, 32'h0000_0000);
        // reserved protocol and options codes, then a disabled entry
        wr(OFS_CONTROL, 32'h0000_0015);
        fr(base, 1'b0);
        wr(OFS_CONTROL, 32'h0000_0601);
        fr(base, 1'b0);
        wr(OFS_CONTROL, 32'h0000_0000);
        fr(base, 1'b0);
    endtask : t_deny
    task automatic test_done;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_regs();
        t_proto();
        t_tri();
        t_addr();
        t_deny();
        test_done();
    end
endmodule : iaem_matcher_bench
